/* rrbd_cfg.svh */
// register offsets, field positions, reset values and timing counts for the bit-decision block
`ifndef RRBD_CFG_SVH
`define RRBD_CFG_SVH

`define RRBD_OFF_THR      8'h00
`define RRBD_OFF_INC      8'h04
`define RRBD_OFF_MODE     8'h08
`define RRBD_OFF_STAT     8'h0c

`define RRBD_DATH_LSB     8
`define RRBD_DATL_LSB     0
`define RRBD_PO_BIT       7
`define RRBD_NC_LSB       0
`define RRBD_PHM_BIT      24

`define RRBD_ST_LVL_BIT   0
`define RRBD_ST_CYC_LSB   8
`define RRBD_ST_BIT_BIT   16
`define RRBD_ST_PAT_LSB   17

`define RRBD_THR_RST      7'h00
`define RRBD_NC_RST       4'h0
`define RRBD_PO_RST       1'b0
`define RRBD_PHM_RST      1'b0
`define RRBD_LVL_RST      1'b1

`define RRBD_CLK_HZ       40000000
`define RRBD_FS_HZ        32768
`define RRBD_FS_DIV       (`RRBD_CLK_HZ / `RRBD_FS_HZ)

`endif

/* rrbd_pkg.sv */
// types shared by the bit-decision block
package rrbd_pkg;
  typedef logic [6:0] rrbd_thr_t;
  typedef logic [3:0] rrbd_nc_t;
  typedef logic [7:0] rrbd_cyc_t;
  typedef enum logic [1:0] {
    RRBD_PAT_00 = 2'b00,
    RRBD_PAT_01 = 2'b01,
    RRBD_PAT_10 = 2'b10
  } rrbd_pat_t;
endpackage

/* rrbd_if.sv */
// link between the decision core and the noise filter
interface rrbd_if;
  import rrbd_pkg::*;
  logic     tick;
  logic     raw;
  rrbd_nc_t nc;
  logic     filt;
  modport core (output tick, output raw, output nc, input filt);
  modport filt_side (input tick, input raw, input nc, output filt);
endinterface

/* rrbd_filter.sv */
// noise filter on the sampling-clock enable
`include "rrbd_cfg.svh"

module rrbd_filter (
  input wire logic    mclk,
  input wire logic    rst,
  rrbd_if.filt_side   link
);
  import rrbd_pkg::*;

  rrbd_nc_t run_q;
  logic     filt_q;

  wire       differ = link.raw != filt_q;
  rrbd_nc_t  run_nx;
  assign run_nx = run_q + 4'h1;
  // zero count means no cancellation: follow the sample at once
  wire       flip   = differ && ((link.nc == 4'h0) || (run_nx == link.nc));

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_q  <= 4'h0;
      filt_q <= `RRBD_LVL_RST;
    end else if (link.tick) begin
      run_q  <= (flip || !differ) ? 4'h0 : run_nx;
      filt_q <= flip ? link.raw : filt_q;
    end
  end

  assign link.filt = filt_q;

  chk_filter_on_tick: assert property (
    @(posedge mclk) disable iff (rst) $changed(filt_q) |-> $past(link.tick))
    else $error("filter output moved without a sample tick");

  chk_filter_run_len: assert property (
    @(posedge mclk) disable iff (rst)
    $changed(filt_q) && $past(link.nc) != 4'h0 |-> $past(run_q) == $past(link.nc) - 4'h1)
    else $error("filter flipped before the programmed run");

  chk_filter_bypass: assert property (
    @(posedge mclk) disable iff (rst)
    link.tick && link.nc == 4'h0 && link.raw != filt_q |=> filt_q == $past(link.raw))
    else $error("zero cancel count did not pass the sample");
endmodule // rrbd_filter

/* rrbd_top.sv */
// bit-decision and input-conditioning core of the remote receiver
//
// Contract
// - phase mode: upper 7-bit threshold in bits 14:8; cycle above it gives 10, else the lower threshold decides.
// - lower 7-bit threshold in bits 6:0; cycle longer than it is 1, else 0.
// - phase mode reuses lower threshold; above it gives 01, otherwise 00.
// - upper threshold ignored when phase mode is 0, applied only when 1.
// - bit 7 of conditioning register inverts the remote input when set.
// - 4-bit noise count in bits 3:0; zero disables, 1 to 15 periods filter.
// - phase-mode bit picks cycle modulation (0) or phase modulation (1).
// - input sampled on the low-speed sampling clock; all times count its periods.
// - filter output flips only after that many consecutive opposite samples.
`include "rrbd_cfg.svh"

module rrbd_top #(
  parameter int FS_DIV = `RRBD_FS_DIV
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          rmt_in,
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wr_data,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output logic      [31:0]   rd_data_q,
  output logic               filt_level_q,
  output rrbd_pkg::rrbd_cyc_t cycle_q,
  output logic               bit_q,
  output rrbd_pkg::rrbd_pat_t pattern_q,
  output logic               decide_q
);
  import rrbd_pkg::*;

  localparam int DIVW = $clog2(FS_DIV + 1);

  rrbd_if link ();

  rrbd_thr_t       dath_q;
  rrbd_thr_t       datl_q;
  rrbd_nc_t        nc_q;
  logic            po_q;
  logic            phm_q;
  logic [1:0]      sync_q;
  logic [DIVW-1:0] div_q;
  logic            tick_q;
  logic            filt_prev_q;
  rrbd_cyc_t       cnt_q;

  // register decode
  wire wr_thr  = wr_en && addr == `RRBD_OFF_THR;
  wire wr_inc  = wr_en && addr == `RRBD_OFF_INC;
  wire wr_mode = wr_en && addr == `RRBD_OFF_MODE;

  always_ff @(posedge mclk) begin
    if (rst) begin
      dath_q <= `RRBD_THR_RST;
      datl_q <= `RRBD_THR_RST;
      nc_q   <= `RRBD_NC_RST;
      po_q   <= `RRBD_PO_RST;
      phm_q  <= `RRBD_PHM_RST;
    end else begin
      // only the defined fields are stored; other bits are dropped
      if (wr_thr) begin
        dath_q <= wr_data[`RRBD_DATH_LSB +: 7];
        datl_q <= wr_data[`RRBD_DATL_LSB +: 7];
      end
      if (wr_inc) begin
        po_q <= wr_data[`RRBD_PO_BIT];
        nc_q <= wr_data[`RRBD_NC_LSB +: 4];
      end
      if (wr_mode) begin
        phm_q <= wr_data[`RRBD_PHM_BIT];
      end
    end
  end

  // read mux: reserved bits are zero, data valid only the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      `RRBD_OFF_THR: begin
        rd_mux[`RRBD_DATH_LSB +: 7] = dath_q;
        rd_mux[`RRBD_DATL_LSB +: 7] = datl_q;
      end
      `RRBD_OFF_INC: begin
        rd_mux[`RRBD_PO_BIT]       = po_q;
        rd_mux[`RRBD_NC_LSB +: 4]  = nc_q;
      end
      `RRBD_OFF_MODE: begin
        rd_mux[`RRBD_PHM_BIT] = phm_q;
      end
      `RRBD_OFF_STAT: begin
        rd_mux[`RRBD_ST_LVL_BIT]     = filt_level_q;
        rd_mux[`RRBD_ST_CYC_LSB +: 8] = cycle_q;
        rd_mux[`RRBD_ST_BIT_BIT]     = bit_q;
        rd_mux[`RRBD_ST_PAT_LSB +: 2] = pattern_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_q <= 2'b11;
    end else begin
      sync_q <= {sync_q[0], rmt_in};
    end
  end

  // sampling-clock enable; the divide rounds down, a slightly fast sample rate
  wire div_end = div_q == DIVW'(FS_DIV - 1);
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_end ? '0 : div_q + DIVW'(1);
      tick_q <= div_end;
    end
  end

  assign link.tick = tick_q;
  assign link.raw  = sync_q[1] ^ po_q;
  assign link.nc   = nc_q;

  rrbd_filter u_filter (
    .mclk (mclk),
    .rst  (rst),
    .link (link)
  );

  // cycle measured falling edge to falling edge in sampling periods
  wire       fall     = filt_prev_q && !link.filt;
  wire       cnt_full = cnt_q == 8'hff;
  wire       over_l   = cnt_q > {1'b0, datl_q};
  wire       over_h   = cnt_q > {1'b0, dath_q};
  rrbd_pat_t pat_d;
  // upper threshold only takes part in phase mode
  assign pat_d = !phm_q ? RRBD_PAT_00 :
                 over_h ? RRBD_PAT_10 :
                 over_l ? RRBD_PAT_01 : RRBD_PAT_00;

  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_prev_q <= `RRBD_LVL_RST;
      cnt_q       <= 8'h00;
    end else begin
      filt_prev_q <= link.filt;
      if (fall) begin
        cnt_q <= 8'h00;
      end else if (tick_q && !cnt_full) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_level_q <= `RRBD_LVL_RST;
      cycle_q      <= 8'h00;
      bit_q        <= 1'b0;
      pattern_q    <= RRBD_PAT_00;
      decide_q     <= 1'b0;
    end else begin
      filt_level_q <= link.filt;
      decide_q     <= fall;
      if (fall) begin
        cycle_q   <= cnt_q;
        bit_q     <= over_l;
        pattern_q <= pat_d;
      end
    end
  end

  chk_bit_decide: assert property (
    @(posedge mclk) disable iff (rst)
    fall |=> decide_q && bit_q == ($past(cnt_q) > {1'b0, $past(datl_q)}))
    else $error("data bit decision wrong");

  chk_pat_upper: assert property (
    @(posedge mclk) disable iff (rst)
    fall && phm_q && cnt_q > {1'b0, dath_q} |=> pattern_q == RRBD_PAT_10)
    else $error("long phase cycle not decided as 10");

  chk_pat_middle: assert property (
    @(posedge mclk) disable iff (rst)
    fall && phm_q && cnt_q <= {1'b0, dath_q} && cnt_q > {1'b0, datl_q}
    |=> pattern_q == RRBD_PAT_01)
    else $error("middle phase cycle not decided as 01");

  chk_pat_short: assert property (
    @(posedge mclk) disable iff (rst)
    fall && phm_q && cnt_q <= {1'b0, datl_q} && cnt_q <= {1'b0, dath_q}
    |=> pattern_q == RRBD_PAT_00)
    else $error("short phase cycle not decided as 00");

  chk_cycle_mode: assert property (
    @(posedge mclk) disable iff (rst)
    fall && !phm_q |=> pattern_q == RRBD_PAT_00 && cycle_q == $past(cnt_q))
    else $error("upper threshold used outside phase mode");

  chk_input_invert: assert property (
    @(posedge mclk) disable iff (rst)
    $stable(po_q) && !$past(rst, 2) |-> link.raw == ($past(rmt_in, 2) ^ po_q))
    else $error("input polarity or synchroniser delay wrong");

  chk_tick_spacing: assert property (
    @(posedge mclk) disable iff (rst) tick_q |=> !tick_q [*8])
    else $error("sampling enable too frequent");

  chk_thr_reserved: assert property (
    @(posedge mclk) disable iff (rst)
    rd_en && addr == `RRBD_OFF_THR |=> (rd_data_q & 32'hffff_8080) == 32'h0000_0000)
    else $error("reserved threshold bits read nonzero");

  chk_inc_reserved: assert property (
    @(posedge mclk) disable iff (rst)
    rd_en && addr == `RRBD_OFF_INC |=> (rd_data_q & 32'hffff_ff70) == 32'h0000_0000)
    else $error("reserved conditioning bits read nonzero");

  chk_read_window: assert property (
    @(posedge mclk) disable iff (rst) !$past(rd_en) |-> rd_data_q == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule // rrbd_top

/* rrbd_remote.sv */
// remote transmitter model driving the receiver input pin
module rrbd_remote #(
  parameter int FS_DIV = 10
) (
  input  wire logic       mclk,
  input  wire logic       valid,
  input  wire logic [7:0] cyc,
  input  wire logic [3:0] glen,
  input  wire logic       inv,
  output logic            take,
  output logic            rmt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        busy_q = 1'b0;
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic [15:0] g_q;
  logic        low;
  // next cycle starts on the last count, so fall spacing stays exact
  assign take = valid && (!busy_q || cnt_q == len_q - 16'h1);
  // edges on sampling-period boundaries keep measured counts exact
  assign low  = busy_q && (cnt_q < 16 * FS_DIV ||
                (cnt_q >= 32 * FS_DIV && cnt_q < (32 + g_q) * FS_DIV));
  assign rmt  = !low ^ inv;
  always @(posedge mclk) begin
    if (take) begin
      busy_q <= 1'b1;
      cnt_q  <= 16'h0;
      len_q  <= 16'(cyc * FS_DIV);
      g_q    <= {12'h0, glen};
    end else if (busy_q) begin
      busy_q <= cnt_q != len_q - 16'h1;
      cnt_q  <= cnt_q + 16'h1;
    end
  end
endmodule // rrbd_remote

/* tb_top.sv */
// self-checking bench for the bit-decision block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rrbd_pkg::*;
  localparam int FSD = 10;
  logic        mclk = 0;
  logic        rst = 1;
  logic        wr_en = 0;
  logic        rd_en = 0;
  logic        valid = 0;
  logic        inv = 0;
  logic [7:0]  addr = 0;
  logic [7:0]  cyc = 0;
  logic [3:0]  glen = 0;
  logic [31:0] wr_data = 0;
  logic [31:0] rd_data;
  logic        rmt, take, filt, bit_o, dec;
  rrbd_cyc_t   cyc_o;
  rrbd_pat_t   pat_o;
  int          fail_count = 0;
  int          n_checks = 0;
  integer      seed = 37;
  logic [10:0] obs[$];

  always #12.5 mclk = ~mclk;

  rrbd_top #(.FS_DIV(FSD)) DUT (.mclk(mclk), .rst(rst), .rmt_in(rmt), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data),
    .filt_level_q(filt), .cycle_q(cyc_o), .bit_q(bit_o), .pattern_q(pat_o), .decide_q(dec));
  rrbd_remote #(.FS_DIV(FSD)) far (.mclk(mclk), .valid(valid), .cyc(cyc), .glen(glen),
    .inv(inv), .take(take), .rmt(rmt));

  always @(posedge mclk) begin
    if (dec === 1'b1) begin
      obs.push_back({cyc_o, bit_o, pat_o});
      chk(filt, 32'h0);
    end
  end

  task results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  function logic [10:0] expd(int c, int lo, int hi, logic phm);
    logic [1:0] p;
    p = !phm ? 2'b00 : (c > hi) ? 2'b10 : (c > lo) ? 2'b01 : 2'b00;
    return {8'(c), c > lo, p};
  endfunction

  // first decision of a burst measures the idle gap, so it is dropped
  task burst(input logic phm, input logic po, input logic [3:0] nc);
    int lo, hi, t;
    int len[8];
    logic [10:0] e;
    // nominal period of 62 samples: lower in 1T..1.5T, upper in 1.5T..2T
    lo = 62 + ($unsigned($random(seed)) % 32);
    hi = 94 + ($unsigned($random(seed)) % 31);
    wr(8'h00, {17'h0, 7'(hi), 1'b0, 7'(lo)});
    wr(8'h04, {24'h0, po, 3'h0, nc});
    wr(8'h08, {7'h0, phm, 24'h0});
    inv <= po;
    glen <= (nc == 0) ? 4'h0 : nc - 4'h1;
    repeat (40 * FSD) @(posedge mclk);
    obs.delete();
    for (int i = 0; i < 8; i++) begin
      len[i] = i == 1 ? lo : i == 2 ? lo + 1 : i == 3 ? hi : i == 4 ? hi + 1 :
               62 + ($unsigned($random(seed)) % 66);
      valid <= 1'b1;
      cyc <= 8'(len[i]);
      for (t = 0; t < 2000; t++) begin
        @(posedge mclk);
        if (take === 1'b1) break;
      end
      if (t == 2000) begin
        fail_count++;
        results;
      end
    end
    valid <= 1'b0;
    repeat (140 * FSD) @(posedge mclk);
    chk(obs.size(), 8);
    for (int i = 1; i < 8; i++) chk(obs[i], expd(len[i-1], lo, hi, phm));
    e = expd(len[6], lo, hi, phm);
    rd(8'h0c, {13'h0, e[1:0], e[2], e[10:3], 7'h0, 1'b1});
    chk(filt, 32'h1);
  endtask

  initial begin
    logic [31:0] d;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(8'h00, d);
      rd(8'h00, d & 32'h7f7f);
      wr(8'h04, d);
      rd(8'h04, d & 32'h8f);
      wr(8'h08, d);
      rd(8'h08, d & 32'h0100_0000);
      wr(8'h20, d);
      rd(8'h20, 32'h0);
    end
    burst(1'b0, 1'b0, 4'h0);
    burst(1'b1, 1'b0, 4'h1);
    burst(1'b0, 1'b1, 4'hf);
    burst(1'b1, 1'b1, 4'h3);
    burst(1'b1, 1'b0, 4'hf);
    results;
  end
endmodule // tb_top
